// ===== logic/ssr_pkg.sv
package ssr_pkg;

  // ---------------------------------------------------------------------
  // Status summary byte bit positions
  // ---------------------------------------------------------------------
  localparam int BYTE_DEV = 1;
  localparam int BYTE_ERRQ = 2;
  localparam int BYTE_QUES = 3;
  localparam int BYTE_MSG = 4;
  localparam int BYTE_STD = 5;
  localparam int BYTE_REQ = 6;
  localparam int BYTE_OPER = 7;

  // ---------------------------------------------------------------------
  // Device condition status bit positions
  // ---------------------------------------------------------------------
  localparam int DEV_SUM = 0;
  localparam int DEV_NOMEAS = 1;
  localparam int DEV_ERRRES = 2;
  localparam int DEV_WARN = 3;
  localparam int DEV_CRIT = 4;
  localparam int DEV_PLL = 8;

  // ---------------------------------------------------------------------
  // Reset values and write masks
  // ---------------------------------------------------------------------
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] SRE_WMASK = 8'hBF; // The summary bit never enables.
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] ESR_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] DEV_RST = 16'h0000;
  localparam logic [15:0] DEV_ENA_RST = 16'h0000;

  // ---------------------------------------------------------------------
  // Indicator blink timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 125;
  localparam int SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam int BLINK_CNT_W = 25;

  // ---------------------------------------------------------------------
  // Host status commands
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    SSR_RD_BYTE,
    SSR_WR_SRE,
    SSR_RD_SRE,
    SSR_WR_ESE,
    SSR_RD_ESE,
    SSR_RD_ESR,
    SSR_RD_DEV_COND,
    SSR_RD_DEV_EVT,
    SSR_WR_DEV_ENA,
    SSR_RD_DEV_ENA
  } ssr_cmd_t;

endpackage : ssr_pkg

// ===== logic/ssr_blink.sv
module ssr_blink #(
  parameter int SLOW_HALF = ssr_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = ssr_pkg::FAST_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_warn,
  input wire logic i_crit,
  output logic o_led_red
);

  logic [ssr_pkg::BLINK_CNT_W-1:0] cnt;
  logic [ssr_pkg::BLINK_CNT_W-1:0] next_cnt;
  logic [ssr_pkg::BLINK_CNT_W-1:0] reload;
  logic phase;
  logic next_phase;
  logic tick;

  // ---------------------------------------------------------------------
  // Half-period divider
  // ---------------------------------------------------------------------
  // Critical wins over warning so the more urgent rate is always shown.
  always_comb begin
    if (i_crit) begin
      reload = ssr_pkg::BLINK_CNT_W'(FAST_HALF - 1); // RULE_12
    end else begin
      reload = ssr_pkg::BLINK_CNT_W'(SLOW_HALF - 1); // RULE_11
    end
    tick = (cnt == '0);
    next_cnt = tick ? reload : cnt - 1'b1;
    if (!(i_warn || i_crit)) begin
      next_phase = 1'b0;
      next_cnt = reload;
    end else if (tick) begin
      next_phase = ~phase;
    end else begin
      next_phase = phase;
    end
  end

  // Registers only; the led is dark while no static error is present.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
      phase <= 1'b0;
    end else begin
      cnt <= next_cnt;
      phase <= next_phase;
    end
  end

  assign o_led_red = phase;

  AST_LED_DARK: assert property ( // RULE_11
    @(posedge i_clk_sys) disable iff (i_rst)
    !(i_warn || i_crit) |=> !o_led_red)
    else $error("Indicator lit without a static error.");

endmodule : ssr_blink

// ===== logic/ssr_status.sv
// Behaviour
// (RULE_01) Byte bit 1: enabled device status events.
// (RULE_02) Byte bit 2: error queue not empty.
// (RULE_03) Byte bit 3: enabled questionable event summary.
// (RULE_04) Byte bit 4: response message waiting.
// (RULE_05) Byte bit 5: enabled standard event summary.
// (RULE_06) Byte bit 6: any enabled byte bit.
// (RULE_07) Byte bit 7: enabled operation event summary.
// (RULE_08) Host writes and reads request enable.
// (RULE_09) Device bit 0 ORs static errors 1-4.
// (RULE_10) Device bits 1, 2: no measurement, doubtful.
// (RULE_11) Device bit 3 warning: slow red blink.
// (RULE_12) Device bit 4 critical: fast red blink.
// (RULE_13) Device bit 8: reference loop locked.
// (RULE_14) Host writes and reads event enable mask.
// (RULE_15) Events latch until read, read clears.
// (RULE_16) Request output follows master summary bit.
module ssr_status #(
  parameter int SLOW_HALF = ssr_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = ssr_pkg::FAST_HALF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire ssr_pkg::ssr_cmd_t i_cmd_code,
  input wire logic [15:0] i_cmd_data,
  input wire logic i_errq_not_empty,
  input wire logic i_errq_push,
  input wire logic i_msg_available,
  input wire logic [15:0] i_ques_event,
  input wire logic [15:0] i_ques_enable,
  input wire logic [15:0] i_oper_event,
  input wire logic [15:0] i_oper_enable,
  input wire logic [7:0] i_std_event_set,
  input wire logic i_meas_impossible,
  input wire logic i_result_doubtful,
  input wire logic i_static_warn,
  input wire logic i_static_crit,
  input wire logic i_pll_locked,
  output logic o_rsp_valid,
  output logic [15:0] o_rsp_data,
  output logic o_srq,
  output logic o_srq_pulse,
  output logic o_led_red
);

  logic [7:0] status_summary_byte;
  logic [7:0] next_byte;
  logic [15:0] device_condition_status;
  logic [15:0] next_dev;
  logic [15:0] dev_prev;
  logic [15:0] dev_event;
  logic [15:0] next_dev_event;
  logic [15:0] dev_enable;
  logic [15:0] next_dev_enable;
  logic [7:0] request_enable;
  logic [7:0] next_sre;
  logic [7:0] event_enable;
  logic [7:0] next_ese;
  logic [7:0] std_event;
  logic [7:0] next_esr;
  logic pll_meta;
  logic pll_sync;
  logic next_srq_pulse;
  logic next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic cmd_ok;
  // Every check here samples on the system clock and rests during reset.
  default clocking ssr_cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // Any bit of an event vector that is also enabled.
  function automatic logic ssr_any(input logic [15:0] ev,
                                   input logic [15:0] en);
    ssr_any = |(ev & en);
  endfunction : ssr_any

  // ---------------------------------------------------------------------
  // Lock input synchroniser
  // ---------------------------------------------------------------------
  // The loop lock comes from the analog reference and is asynchronous.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pll_meta <= 1'b0;
      pll_sync <= 1'b0;
    end else begin
      pll_meta <= i_pll_locked;
      pll_sync <= pll_meta;
    end
  end

  // ---------------------------------------------------------------------
  // Device condition and event registers
  // ---------------------------------------------------------------------
  // Conditions follow their sources; events catch rising conditions and
  // hold them until the event query, where a new rise beats the clear.
  always_comb begin
    next_dev = '0;
    next_dev[ssr_pkg::DEV_NOMEAS] = i_meas_impossible; // RULE_10
    next_dev[ssr_pkg::DEV_ERRRES] = i_result_doubtful; // RULE_10
    next_dev[ssr_pkg::DEV_WARN] = i_static_warn; // RULE_11
    next_dev[ssr_pkg::DEV_CRIT] = i_static_crit; // RULE_12
    next_dev[ssr_pkg::DEV_SUM] = i_meas_impossible | i_result_doubtful |
      i_static_warn | i_static_crit; // RULE_09
    next_dev[ssr_pkg::DEV_PLL] = pll_sync; // RULE_13
    next_dev_event = dev_event;
    if (cmd_ok && i_cmd_code == ssr_pkg::SSR_RD_DEV_EVT) begin
      next_dev_event = '0; // RULE_15
    end
    next_dev_event = next_dev_event |
      (device_condition_status & ~dev_prev); // RULE_15
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      device_condition_status <= ssr_pkg::DEV_RST;
      dev_prev <= ssr_pkg::DEV_RST;
      dev_event <= ssr_pkg::DEV_RST;
    end else begin
      device_condition_status <= next_dev;
      dev_prev <= device_condition_status;
      dev_event <= next_dev_event;
    end
  end

  // ---------------------------------------------------------------------
  // Enable registers and standard event latch
  // ---------------------------------------------------------------------
  assign cmd_ok = i_cmd_valid;

  always_comb begin
    next_sre = request_enable;
    next_ese = event_enable;
    next_dev_enable = dev_enable;
    next_esr = std_event;
    if (cmd_ok) begin
      unique case (i_cmd_code)
        ssr_pkg::SSR_WR_SRE: begin
          next_sre = i_cmd_data[7:0] & ssr_pkg::SRE_WMASK; // RULE_08
        end
        ssr_pkg::SSR_WR_ESE: next_ese = i_cmd_data[7:0]; // RULE_14
        ssr_pkg::SSR_WR_DEV_ENA: next_dev_enable = i_cmd_data; // RULE_01
        ssr_pkg::SSR_RD_ESR: next_esr = '0; // RULE_15
        default: next_esr = std_event;
      endcase
    end
    // A standard event arriving with the query is kept, not lost.
    next_esr = next_esr | i_std_event_set; // RULE_15
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      request_enable <= ssr_pkg::SRE_RST;
      event_enable <= ssr_pkg::ESE_RST;
      dev_enable <= ssr_pkg::DEV_ENA_RST;
      std_event <= ssr_pkg::ESR_RST;
    end else begin
      request_enable <= next_sre;
      event_enable <= next_ese;
      dev_enable <= next_dev_enable;
      std_event <= next_esr;
    end
  end

  // ---------------------------------------------------------------------
  // Status summary byte and service request
  // ---------------------------------------------------------------------
  // The byte is registered, so every summary lags its cause by one cycle.
  always_comb begin
    next_byte = '0;
    next_byte[ssr_pkg::BYTE_DEV] = ssr_any(dev_event, dev_enable); // RULE_01
    next_byte[ssr_pkg::BYTE_ERRQ] = i_errq_not_empty; // RULE_02
    next_byte[ssr_pkg::BYTE_QUES] =
      ssr_any(i_ques_event, i_ques_enable); // RULE_03
    next_byte[ssr_pkg::BYTE_MSG] = i_msg_available; // RULE_04
    next_byte[ssr_pkg::BYTE_STD] = |(std_event & event_enable); // RULE_05
    next_byte[ssr_pkg::BYTE_OPER] =
      ssr_any(i_oper_event, i_oper_enable); // RULE_07
    next_byte[ssr_pkg::BYTE_REQ] = |(next_byte & request_enable); // RULE_06
    // A fresh error entry requests service even if the bit already stood.
    next_srq_pulse = (next_byte[ssr_pkg::BYTE_REQ] &
      ~status_summary_byte[ssr_pkg::BYTE_REQ]) |
      (i_errq_push & request_enable[ssr_pkg::BYTE_ERRQ]); // RULE_02
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      status_summary_byte <= ssr_pkg::BYTE_RST;
      o_srq_pulse <= 1'b0;
    end else begin
      status_summary_byte <= next_byte;
      o_srq_pulse <= next_srq_pulse;
    end
  end

  assign o_srq = status_summary_byte[ssr_pkg::BYTE_REQ]; // RULE_16

  // ---------------------------------------------------------------------
  // Query responses
  // ---------------------------------------------------------------------
  // Reads answer one cycle after the command; writes give no answer.
  always_comb begin
    next_rsp_valid = 1'b0;
    next_rsp_data = o_rsp_data;
    if (cmd_ok) begin
      next_rsp_valid = 1'b1;
      unique case (i_cmd_code)
        ssr_pkg::SSR_RD_BYTE: next_rsp_data = {8'h00, status_summary_byte};
        ssr_pkg::SSR_RD_SRE: next_rsp_data = {8'h00, request_enable};
        ssr_pkg::SSR_RD_ESE: next_rsp_data = {8'h00, event_enable};
        ssr_pkg::SSR_RD_ESR: next_rsp_data = {8'h00, std_event};
        ssr_pkg::SSR_RD_DEV_COND: next_rsp_data = device_condition_status;
        ssr_pkg::SSR_RD_DEV_EVT: next_rsp_data = dev_event;
        ssr_pkg::SSR_RD_DEV_ENA: next_rsp_data = dev_enable;
        default: next_rsp_valid = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_data <= '0;
    end else begin
      o_rsp_valid <= next_rsp_valid;
      o_rsp_data <= next_rsp_data;
    end
  end

  // ---------------------------------------------------------------------
  // Status indicator
  // ---------------------------------------------------------------------
  ssr_blink #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_blink (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_warn(device_condition_status[ssr_pkg::DEV_WARN]),
    .i_crit(device_condition_status[ssr_pkg::DEV_CRIT]),
    .o_led_red(o_led_red)
  );

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  AST_DEV_SUMMARY: assert property ( // RULE_01
    |(dev_event & dev_enable) |=> status_summary_byte[ssr_pkg::BYTE_DEV])
    else $error("Device summary bit missed an enabled event.");
  AST_ERRQ: assert property ( // RULE_02
    status_summary_byte[ssr_pkg::BYTE_ERRQ] == $past(i_errq_not_empty))
    else $error("Error queue bit does not follow the queue.");
  AST_ERRQ_SRQ: assert property ( // RULE_02
    (i_errq_push && request_enable[ssr_pkg::BYTE_ERRQ]) |=> o_srq_pulse)
    else $error("New error entry raised no request.");
  AST_QUES: assert property ( // RULE_03
    |(i_ques_event & i_ques_enable) |=>
      status_summary_byte[ssr_pkg::BYTE_QUES])
    else $error("Questionable summary missed.");
  AST_MSG: assert property ( // RULE_04
    status_summary_byte[ssr_pkg::BYTE_MSG] == $past(i_msg_available))
    else $error("Message bit does not follow the queue.");
  AST_STD: assert property ( // RULE_05
    |(std_event & event_enable) |=> status_summary_byte[ssr_pkg::BYTE_STD])
    else $error("Standard event summary missed.");
  // The byte was formed with the enable of the cycle before, not today's.
  AST_REQ: assert property ( // RULE_06
    status_summary_byte[ssr_pkg::BYTE_REQ] == |(status_summary_byte &
      $past(request_enable) & ssr_pkg::SRE_WMASK))
    else $error("Master summary disagrees with enabled bits.");
  AST_OPER: assert property ( // RULE_07
    |(i_oper_event & i_oper_enable) |=>
      status_summary_byte[ssr_pkg::BYTE_OPER])
    else $error("Operation summary missed.");
  AST_SRE_WR: assert property ( // RULE_08
    (i_cmd_valid && i_cmd_code == ssr_pkg::SSR_WR_SRE) |=>
      request_enable == ($past(i_cmd_data[7:0]) & ssr_pkg::SRE_WMASK))
    else $error("Request enable write lost.");
  AST_DEV_OR: assert property ( // RULE_09
    device_condition_status[ssr_pkg::DEV_SUM] ==
      |device_condition_status[ssr_pkg::DEV_CRIT:ssr_pkg::DEV_NOMEAS])
    else $error("Static error sum wrong.");
  AST_PLL: assert property ( // RULE_13
    $rose(device_condition_status[ssr_pkg::DEV_PLL]) |->
      $past(i_pll_locked, 3))
    else $error("Lock bit set without a synchronised lock.");
  AST_ESE_WR: assert property ( // RULE_14
    (i_cmd_valid && i_cmd_code == ssr_pkg::SSR_WR_ESE) |=>
      event_enable == $past(i_cmd_data[7:0]))
    else $error("Event enable write lost.");
  AST_ESR_CLR: assert property ( // RULE_15
    (i_cmd_valid && i_cmd_code == ssr_pkg::SSR_RD_ESR) |=>
      std_event == $past(i_std_event_set))
    else $error("Standard event register not cleared by its query.");
  AST_SRQ_OUT: assert property ( // RULE_16
    $rose(o_srq) |-> o_srq_pulse)
    else $error("Request output rose without a request pulse.");

endmodule : ssr_status

// ===== testbench/ssr_host_model.sv
module ssr_host_model (
  input wire logic i_clk_sys,
  input wire logic i_rsp_valid,
  input wire logic [15:0] i_rsp_data,
  output logic o_cmd_valid,
  output ssr_pkg::ssr_cmd_t o_cmd_code,
  output logic [15:0] o_cmd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------------
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = ssr_pkg::SSR_RD_BYTE;
    o_cmd_data = 16'h0000;
  end

  // One command is a single-cycle strobe. The data is inverted afterwards
  // so a device that samples it outside the strobe sees garbage.
  task automatic issue(input ssr_pkg::ssr_cmd_t code,
                       input logic [15:0] data);
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= code;
    o_cmd_data <= data;
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b0;
    o_cmd_data <= ~data;
  endtask : issue

  // Write of an enable register; no answer is expected.
  task automatic wr(input ssr_pkg::ssr_cmd_t code,
                    input logic [15:0] data);
    issue(code, data);
  endtask : wr

  // Read: the answer is taken at the first settled edge that shows it.
  // The wait is bounded; ok stays low when no answer came.
  task automatic rd(input ssr_pkg::ssr_cmd_t code,
                    output logic [15:0] data, output logic ok);
    ok = 1'b0;
    data = 16'h0000;
    issue(code, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      #1;
      if (i_rsp_valid === 1'b1) begin
        ok = 1'b1;
        data = i_rsp_data;
        return;
      end
      @(posedge i_clk_sys);
    end
  endtask : rd

endmodule : ssr_host_model

// ===== testbench/status_byte_service_request_tb.sv
module status_byte_service_request_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic i_clk_sys, i_rst, i_cmd_valid, i_errq_not_empty, i_errq_push;
  logic i_msg_available, i_meas_impossible, i_result_doubtful;
  logic i_static_warn, i_static_crit, i_pll_locked;
  logic o_rsp_valid, o_srq, o_srq_pulse, o_led_red;
  ssr_pkg::ssr_cmd_t i_cmd_code;
  logic [15:0] i_cmd_data, o_rsp_data;
  logic [15:0] i_ques_event, i_ques_enable, i_oper_event, i_oper_enable;
  logic [7:0] i_std_event_set;
  int fail_count, checks;

  // ---------------------------------------------------------------------
  // Clock, host model and device
  // ---------------------------------------------------------------------
  initial i_clk_sys = 1'b0;
  always #12.5 i_clk_sys = ~i_clk_sys;

  ssr_host_model u_host (.i_clk_sys(i_clk_sys), .i_rsp_valid(o_rsp_valid),
    .i_rsp_data(o_rsp_data), .o_cmd_valid(i_cmd_valid),
    .o_cmd_code(i_cmd_code), .o_cmd_data(i_cmd_data));

  // Short blink halves keep the indicator checks within a few dozen cycles.
  ssr_status #(.SLOW_HALF(8), .FAST_HALF(3)) u_dut (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
    .i_cmd_data(i_cmd_data), .i_errq_not_empty(i_errq_not_empty),
    .i_errq_push(i_errq_push), .i_msg_available(i_msg_available),
    .i_ques_event(i_ques_event), .i_ques_enable(i_ques_enable),
    .i_oper_event(i_oper_event), .i_oper_enable(i_oper_enable),
    .i_std_event_set(i_std_event_set),
    .i_meas_impossible(i_meas_impossible),
    .i_result_doubtful(i_result_doubtful), .i_static_warn(i_static_warn),
    .i_static_crit(i_static_crit), .i_pll_locked(i_pll_locked),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_srq(o_srq),
    .o_srq_pulse(o_srq_pulse), .o_led_red(o_led_red));

  // ---------------------------------------------------------------------
  // Checking and reporting
  // ---------------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk16(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  // A read without an answer ends the run through the closing report.
  task automatic rd_chk(input string what, input ssr_pkg::ssr_cmd_t code,
                        input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_host.rd(code, d, ok);
    if (!ok) begin
      fail_count++;
      $display("Error %s expected answer seen none", what);
      finish_test();
    end else begin
      chk16(what, exp, d);
    end
  endtask : rd_chk

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : wt

  // Counts indicator changes over a fixed window of cycles.
  task automatic led_toggles(output int n);
    logic last;
    n = 0;
    last = o_led_red;
    repeat (64) begin
      @(posedge i_clk_sys);
      #1;
      if (o_led_red !== last) n++;
      last = o_led_red;
    end
  endtask : led_toggles

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    int n;
    logic seen;
    fail_count = 0;
    checks = 0;
    i_rst = 1'b1;
    {i_errq_not_empty, i_errq_push, i_msg_available} = 3'b000;
    {i_meas_impossible, i_result_doubtful} = 2'b00;
    {i_static_warn, i_static_crit, i_pll_locked} = 3'b000;
    {i_ques_event, i_ques_enable} = 32'h0000_0000;
    {i_oper_event, i_oper_enable} = 32'h0000_0000;
    i_std_event_set = 8'h00;
    wt(2);
    i_rst <= 1'b0;
    rd_chk("byte at reset", ssr_pkg::SSR_RD_BYTE, 16'h0000);
    rd_chk("request enable reset", ssr_pkg::SSR_RD_SRE, 16'h0000);
    u_host.wr(ssr_pkg::SSR_WR_SRE, 16'h00FF);
    rd_chk("request enable", ssr_pkg::SSR_RD_SRE, 16'h00BF);
    u_host.wr(ssr_pkg::SSR_WR_ESE, 16'h0024);
    rd_chk("event enable", ssr_pkg::SSR_RD_ESE, 16'h0024);
    $display("Test registers done");
    // Error queue level, service request and per-entry request pulse.
    @(posedge i_clk_sys) i_errq_not_empty <= 1'b1;
    wt(4);
    rd_chk("byte error queue", ssr_pkg::SSR_RD_BYTE, 16'h0044);
    chk1("request line", 1'b1, o_srq);
    @(posedge i_clk_sys) i_errq_not_empty <= 1'b0;
    wt(4);
    #1 chk1("request line idle", 1'b0, o_srq);
    @(posedge i_clk_sys) i_errq_push <= 1'b1;
    @(posedge i_clk_sys) i_errq_push <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1 seen |= (o_srq_pulse === 1'b1);
      @(posedge i_clk_sys);
    end
    chk1("request pulse per entry", 1'b1, seen);
    $display("Test error queue done");
    // Message waiting, questionable and operation summaries.
    @(posedge i_clk_sys) i_msg_available <= 1'b1;
    wt(4);
    rd_chk("byte message", ssr_pkg::SSR_RD_BYTE, 16'h0050);
    @(posedge i_clk_sys) i_msg_available <= 1'b0;
    i_ques_event <= 16'h0100;
    wt(4);
    rd_chk("byte unenabled", ssr_pkg::SSR_RD_BYTE, 16'h0000);
    @(posedge i_clk_sys) i_ques_enable <= 16'h0100;
    wt(4);
    rd_chk("byte questionable", ssr_pkg::SSR_RD_BYTE, 16'h0048);
    @(posedge i_clk_sys) i_ques_event <= 16'h0000;
    i_oper_event <= 16'h0010;
    i_oper_enable <= 16'h0010;
    wt(4);
    rd_chk("byte operation", ssr_pkg::SSR_RD_BYTE, 16'h00C0);
    @(posedge i_clk_sys) i_oper_event <= 16'h0000;
    $display("Test summaries done");
    // Standard events latch until read; only enabled ones reach the byte.
    @(posedge i_clk_sys) i_std_event_set <= 8'h21;
    @(posedge i_clk_sys) i_std_event_set <= 8'h00;
    wt(4);
    rd_chk("byte standard", ssr_pkg::SSR_RD_BYTE, 16'h0060);
    rd_chk("event read", ssr_pkg::SSR_RD_ESR, 16'h0021);
    rd_chk("event cleared", ssr_pkg::SSR_RD_ESR, 16'h0000);
    wt(4);
    rd_chk("byte after clear", ssr_pkg::SSR_RD_BYTE, 16'h0000);
    $display("Test standard events done");
    // Device condition bits, device events and the indicator.
    rd_chk("dev events empty", ssr_pkg::SSR_RD_DEV_EVT, 16'h0000);
    u_host.wr(ssr_pkg::SSR_WR_DEV_ENA, 16'h0008);
    rd_chk("device enable", ssr_pkg::SSR_RD_DEV_ENA, 16'h0008);
    @(posedge i_clk_sys) i_static_warn <= 1'b1;
    wt(6);
    rd_chk("byte device", ssr_pkg::SSR_RD_BYTE, 16'h0042);
    rd_chk("cond warn", ssr_pkg::SSR_RD_DEV_COND, 16'h0009);
    led_toggles(n);
    chk1("slow blink", 1'b1, n >= 7 && n <= 9);
    rd_chk("dev events", ssr_pkg::SSR_RD_DEV_EVT, 16'h0009);
    rd_chk("dev cleared", ssr_pkg::SSR_RD_DEV_EVT, 16'h0000);
    wt(4);
    rd_chk("byte dev clear", ssr_pkg::SSR_RD_BYTE, 16'h0000);
    @(posedge i_clk_sys) i_static_warn <= 1'b0;
    i_static_crit <= 1'b1;
    wt(6);
    rd_chk("cond crit", ssr_pkg::SSR_RD_DEV_COND, 16'h0011);
    led_toggles(n);
    chk1("fast blink", 1'b1, n >= 20 && n <= 22);
    @(posedge i_clk_sys) i_static_crit <= 1'b0;
    {i_meas_impossible, i_result_doubtful} <= 2'b11;
    wt(6);
    rd_chk("cond errors", ssr_pkg::SSR_RD_DEV_COND, 16'h0007);
    #1 chk1("indicator off", 1'b0, o_led_red);
    @(posedge i_clk_sys) {i_meas_impossible, i_result_doubtful} <= 2'b00;
    i_pll_locked <= 1'b1;
    wt(6);
    rd_chk("cond lock", ssr_pkg::SSR_RD_DEV_COND, 16'h0100);
    $display("Test device status done");
    finish_test();
  end

endmodule : status_byte_service_request_tb
